// >>> common/csw_defs.vh
// Constants for the chip select and wait controller.
// Assumes a 32-bit AXI4-Lite register port and a 24-bit external address.
`ifndef CSW_DEFS_VH
`define CSW_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_BLOCK0       8'h68
`define IDX_BLOCK1       8'h69
`define IDX_BLOCK2       8'h6a
`define IDX_STATUS       8'h6b

// Control register fields
`define F_ENABLE         7
`define F_SYSTEM_ONLY    6
`define F_STROBE_TYPE    5
`define F_BUS_WIDTH      4
`define F_WAIT_HI        3
`define F_WAIT_LO        2
`define F_REGION_HI      1
`define F_REGION_LO      0

// Reset values
`define RST_BLOCK0       8'h00
`define RST_BLOCK1       8'h00
`define RST_BLOCK2       8'h80

// Wait codes
`define WAIT_TWO         2'b00
`define WAIT_ONE         2'b01
`define WAIT_ONE_N       2'b10
`define WAIT_NONE        2'b11

// Base access length in clock cycles, before wait states
`define ACCESS_BASE      4'h2

// Region bounds
`define B0_LOW_START     24'h00_7f00
`define B0_LOW_START_NR  24'h00_0080
`define B0_LOW_END       24'h00_7fff
`define B1_LOW_START     24'h48_0000
`define B1_LOW_END       24'h7f_ffff
`define B2_LOW_START     24'h80_0000
`define B2_LOW_END       24'hff_ffff
`define REGION_01_START  24'h40_0000
`define REGION_10_START  24'h80_0000
`define REGION_11_START  24'hc0_0000
`define QUADRANT_MASK    24'h3f_ffff

// AXI responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// >>> src/chip_select_wait_control.v
// Three-block chip select and wait-state controller for an external bus.
// Assumes acc_* inputs come from logic on mclk; wait_pin_b is a raw pin.
//
// Operation
// - Each block has an enable bit; after reset only block 2 is enabled.
// - After reset block 2 runs 16-bit bus with two wait states.
// - Control register writes take effect only from system mode accesses.
// - Bus-width bit 0 selects 16-bit bus, 1 selects 8-bit bus.
// - Wait code 00 two, 01 one, 10 one plus extension, 11 none.
// - Strobe-type bit routes decode to chip select (0) or column strobe (1).
// - Block 0 regions: 7F00-7FFF, 400000, 800000, C00000 for codes 00-11.
// - Without internal RAM, block 0 code 00 covers 80 up to 7FFF.
// - Block 1 region starts 480000, 400000, 800000, C00000 for codes 00-11.
// - Block 2 region starts 800000, 400000, 800000, C00000 for codes 00-11.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "csw_defs.vh"

module chip_select_wait_control #(
	parameter NO_INT_RAM = 0,
	parameter AW         = 12
) (
	// Clock and reset
	input  wire          mclk,
	input  wire          rst_b,
	// AXI4-Lite write address and data
	input  wire [AW-1:0] awaddr,
	input  wire [2:0]    awprot,
	input  wire          awvalid,
	output reg           awready,
	input  wire [31:0]   wdata,
	input  wire [3:0]    wstrb,
	input  wire          wvalid,
	output reg           wready,
	// AXI4-Lite write response
	output reg  [1:0]    bresp,
	output reg           bvalid,
	input  wire          bready,
	// AXI4-Lite read
	input  wire [AW-1:0] araddr,
	input  wire [2:0]    arprot,
	input  wire          arvalid,
	output reg           arready,
	output reg  [31:0]   rdata,
	output reg  [1:0]    rresp,
	output reg           rvalid,
	input  wire          rready,
	// External access request from the CPU
	input  wire          acc_start,
	input  wire [23:0]   acc_addr,
	input  wire          acc_system,
	input  wire          wait_pin_b,
	// External bus outputs
	output reg           select_out_0,
	output reg           select_out_1,
	output reg           select_out_2,
	output reg           column_strobe_out_0,
	output reg           column_strobe_out_1,
	output reg           column_strobe_out_2,
	output reg           bus_8bit,
	output reg           acc_busy,
	output reg           acc_done
);

	localparam ST_IDLE   = 1'b0;
	localparam ST_ACCESS = 1'b1;

	reg  [7:0]  block0_select_ctrl;
	reg  [7:0]  block1_select_ctrl;
	reg  [7:0]  block2_select_ctrl;

	// Write channel holding registers
	reg         aw_held;
	reg  [9:0]  aw_idx;
	reg         aw_sys;
	reg         w_held;
	reg  [7:0]  w_byte;
	reg         w_lane;

	// Access sequencer
	reg         state;
	reg  [3:0]  cnt;
	reg         ext_mode;
	reg         wait_s1;
	reg         wait_s2;

	// Region decode
	reg  [23:0] b0_start;
	reg  [23:0] b0_end;
	reg  [23:0] b1_start;
	reg  [23:0] b1_end;
	reg  [23:0] b2_start;
	reg  [23:0] b2_end;
	reg  [2:0]  hit;
	reg  [7:0]  sel_ctrl;
	reg  [1:0]  sel_blk;
	reg         sel_any;
	reg  [3:0]  next_cnt;

	wire [7:0]  status;
	wire [7:0]  ctrl [0:2];

	assign ctrl[0] = block0_select_ctrl;
	assign ctrl[1] = block1_select_ctrl;
	assign ctrl[2] = block2_select_ctrl;
	assign status = {bus_8bit, acc_busy,
		column_strobe_out_2, column_strobe_out_1, column_strobe_out_0,
		select_out_2, select_out_1, select_out_0};

	// Region start and end for each block
	always @* begin
		case (block0_select_ctrl[`F_REGION_HI:`F_REGION_LO])
		2'b00: begin
			b0_start = NO_INT_RAM ? `B0_LOW_START_NR : `B0_LOW_START;
			b0_end   = `B0_LOW_END;
		end
		2'b01: begin
			b0_start = `REGION_01_START;
			b0_end   = `REGION_01_START | `QUADRANT_MASK;
		end
		2'b10: begin
			b0_start = `REGION_10_START;
			b0_end   = `REGION_10_START | `QUADRANT_MASK;
		end
		default: begin
			b0_start = `REGION_11_START;
			b0_end   = `REGION_11_START | `QUADRANT_MASK;
		end
		endcase
		case (block1_select_ctrl[`F_REGION_HI:`F_REGION_LO])
		2'b00: begin
			b1_start = `B1_LOW_START;
			b1_end   = `B1_LOW_END;
		end
		2'b01: begin
			b1_start = `REGION_01_START;
			b1_end   = `REGION_01_START | `QUADRANT_MASK;
		end
		2'b10: begin
			b1_start = `REGION_10_START;
			b1_end   = `REGION_10_START | `QUADRANT_MASK;
		end
		default: begin
			b1_start = `REGION_11_START;
			b1_end   = `REGION_11_START | `QUADRANT_MASK;
		end
		endcase
		case (block2_select_ctrl[`F_REGION_HI:`F_REGION_LO])
		2'b00: begin
			b2_start = `B2_LOW_START;
			b2_end   = `B2_LOW_END;
		end
		2'b01: begin
			b2_start = `REGION_01_START;
			b2_end   = `REGION_01_START | `QUADRANT_MASK;
		end
		2'b10: begin
			b2_start = `REGION_10_START;
			b2_end   = `REGION_10_START | `QUADRANT_MASK;
		end
		default: begin
			b2_start = `REGION_11_START;
			b2_end   = `REGION_11_START | `QUADRANT_MASK;
		end
		endcase
	end

	// Per-block hit: enabled, in region, and mode allowed
	always @* begin
		hit[0] = (acc_addr >= b0_start) && (acc_addr <= b0_end);
		hit[1] = (acc_addr >= b1_start) && (acc_addr <= b1_end);
		hit[2] = (acc_addr >= b2_start) && (acc_addr <= b2_end);
		hit = hit & {ctrl[2][`F_ENABLE], ctrl[1][`F_ENABLE],
			ctrl[0][`F_ENABLE]};
		hit = hit & ~({ctrl[2][`F_SYSTEM_ONLY], ctrl[1][`F_SYSTEM_ONLY],
			ctrl[0][`F_SYSTEM_ONLY]} & {3{~acc_system}});
	end

	// Lowest numbered block wins an overlap
	always @* begin
		sel_any = |hit;
		if (hit[0]) begin
			sel_blk = 2'd0;
		end else if (hit[1]) begin
			sel_blk = 2'd1;
		end else begin
			sel_blk = 2'd2;
		end
		sel_ctrl = sel_any ? ctrl[sel_blk] : 8'h00;
	end

	// Cycle count for the selected wait code
	always @* begin
		case (sel_ctrl[`F_WAIT_HI:`F_WAIT_LO])
		`WAIT_TWO:   next_cnt = `ACCESS_BASE + 4'h2;
		`WAIT_ONE:   next_cnt = `ACCESS_BASE + 4'h1;
		`WAIT_ONE_N: next_cnt = `ACCESS_BASE + 4'h1;
		default:     next_cnt = `ACCESS_BASE;
		endcase
	end

	// Wait pin synchroniser
	always @(posedge mclk) begin
		if (!rst_b) begin
			wait_s1 <= 1'b1;
			wait_s2 <= 1'b1;
		end else begin
			wait_s1 <= wait_pin_b;
			wait_s2 <= wait_s1;
		end
	end

	// Access sequencer driving select, strobe and width outputs
	always @(posedge mclk) begin
		if (!rst_b) begin
			state               <= ST_IDLE;
			cnt                 <= 4'h0;
			ext_mode            <= 1'b0;
			select_out_0        <= 1'b0;
			select_out_1        <= 1'b0;
			select_out_2        <= 1'b0;
			column_strobe_out_0 <= 1'b0;
			column_strobe_out_1 <= 1'b0;
			column_strobe_out_2 <= 1'b0;
			bus_8bit            <= 1'b0;
			acc_busy            <= 1'b0;
			acc_done            <= 1'b0;
		end else begin
			acc_done <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (acc_start) begin
					state    <= ST_ACCESS;
					acc_busy <= 1'b1;
					cnt      <= next_cnt - 4'h1;
					ext_mode <= (sel_ctrl[`F_WAIT_HI:`F_WAIT_LO] ==
						`WAIT_ONE_N);
					bus_8bit <= sel_ctrl[`F_BUS_WIDTH];
					select_out_0 <= hit[0] && !sel_ctrl[`F_STROBE_TYPE]
						&& sel_blk == 2'd0;
					select_out_1 <= hit[1] && !sel_ctrl[`F_STROBE_TYPE]
						&& sel_blk == 2'd1;
					select_out_2 <= hit[2] && !sel_ctrl[`F_STROBE_TYPE]
						&& sel_blk == 2'd2;
					column_strobe_out_0 <= hit[0] && sel_ctrl[`F_STROBE_TYPE]
						&& sel_blk == 2'd0;
					column_strobe_out_1 <= hit[1] && sel_ctrl[`F_STROBE_TYPE]
						&& sel_blk == 2'd1;
					column_strobe_out_2 <= hit[2] && sel_ctrl[`F_STROBE_TYPE]
						&& sel_blk == 2'd2;
				end
			end
			ST_ACCESS: begin
				if (cnt != 4'h0) begin
					cnt <= cnt - 4'h1;
				end else if (!(ext_mode && !wait_s2)) begin
					state               <= ST_IDLE;
					acc_busy            <= 1'b0;
					acc_done            <= 1'b1;
					select_out_0        <= 1'b0;
					select_out_1        <= 1'b0;
					select_out_2        <= 1'b0;
					column_strobe_out_0 <= 1'b0;
					column_strobe_out_1 <= 1'b0;
					column_strobe_out_2 <= 1'b0;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// AXI write: address and data taken in either order
	always @(posedge mclk) begin
		if (!rst_b) begin
			awready            <= 1'b1;
			wready             <= 1'b1;
			aw_held            <= 1'b0;
			aw_idx             <= 10'h000;
			aw_sys             <= 1'b0;
			w_held             <= 1'b0;
			w_byte             <= 8'h00;
			w_lane             <= 1'b0;
			bvalid             <= 1'b0;
			bresp              <= `RESP_OKAY;
			block0_select_ctrl <= `RST_BLOCK0;
			block1_select_ctrl <= `RST_BLOCK1;
			block2_select_ctrl <= `RST_BLOCK2;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				awready <= 1'b0;
				aw_idx  <= awaddr[AW-1:2];
				aw_sys  <= awprot[0];
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wready <= 1'b0;
				w_byte <= wdata[7:0];
				w_lane <= wstrb[0];
			end
			if (aw_held && w_held && !bvalid) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				if (aw_idx != {2'b00, `IDX_BLOCK0} &&
				    aw_idx != {2'b00, `IDX_BLOCK1} &&
				    aw_idx != {2'b00, `IDX_BLOCK2}) begin
					bresp <= `RESP_SLVERR;
				end else if (!aw_sys) begin
					bresp <= `RESP_SLVERR;
				end else begin
					bresp <= `RESP_OKAY;
					if (w_lane && aw_idx == {2'b00, `IDX_BLOCK0})
						block0_select_ctrl <= w_byte;
					if (w_lane && aw_idx == {2'b00, `IDX_BLOCK1})
						block1_select_ctrl <= w_byte;
					if (w_lane && aw_idx == {2'b00, `IDX_BLOCK2})
						block2_select_ctrl <= w_byte;
				end
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// AXI read: control registers read zero, status shows the sequencer
	always @(posedge mclk) begin
		if (!rst_b) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= 32'h0000_0000;
				rresp   <= `RESP_OKAY;
				if (araddr[AW-1:2] == {2'b00, `IDX_STATUS}) begin
					rdata <= {24'h00_0000, status};
				end else if (araddr[AW-1:2] != {2'b00, `IDX_BLOCK0} &&
				    araddr[AW-1:2] != {2'b00, `IDX_BLOCK1} &&
				    araddr[AW-1:2] != {2'b00, `IDX_BLOCK2}) begin
					rresp <= `RESP_SLVERR;
				end
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule

// >>> verif/csw_asserts.sv
// Port checker for the chip select and wait controller.
// Assumes one mclk domain with synchronous active-low rst_b.
`timescale 1ns/1ps
module csw_asserts (
	// Clock and reset
	input wire        mclk,
	input wire        rst_b,
	// Register write path
	input wire        awvalid,
	input wire        awready,
	input wire [2:0]  awprot,
	input wire        bvalid,
	input wire [1:0]  bresp,
	// Access port
	input wire        acc_start,
	input wire [23:0] acc_addr,
	input wire        acc_busy,
	input wire        acc_done,
	// External strobes
	input wire        select_out_0,
	input wire        select_out_1,
	input wire        select_out_2,
	input wire        column_strobe_out_0,
	input wire        column_strobe_out_1,
	input wire        column_strobe_out_2,
	input wire        bus_8bit
);
	wire  any;
	logic touched;
	assign any = select_out_0 | select_out_1 | select_out_2 |
		column_strobe_out_0 | column_strobe_out_1 | column_strobe_out_2;
	// Boot settings hold until software first writes
	always @(posedge mclk) begin
		if (!rst_b)
			touched <= 1'h0;
		else if (awvalid && awready)
			touched <= 1'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence s_take;
		acc_start && !acc_busy;
	endsequence
	sequence s_end;
		acc_done && !acc_busy && !any;
	endsequence
	property p_one_strobe;
		$onehot0({select_out_0, select_out_1, select_out_2,
			column_strobe_out_0, column_strobe_out_1, column_strobe_out_2});
	endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("two strobes active");
	property p_take_len;
		s_take |=> acc_busy ##[1:30] s_end;
	endproperty
	a_take_len: assert property (p_take_len)
		else $error("access did not end in time");
	// Boot block 2 with two waits keeps its select for four cycles
	property p_boot;
		s_take ##0 (!touched && acc_addr[23]) |=>
			(select_out_2 && !bus_8bit)[*4] ##1 s_end;
	endproperty
	a_boot: assert property (p_boot)
		else $error("boot access wrong");
	property p_sel_cause;
		$rose(any) |-> $past(acc_start) && acc_busy;
	endproperty
	a_sel_cause: assert property (p_sel_cause)
		else $error("strobe without request");
	property p_sel_busy;
		any |-> acc_busy;
	endproperty
	a_sel_busy: assert property (p_sel_busy)
		else $error("strobe outside access");
	property p_sel_end;
		$fell(any) |-> acc_done;
	endproperty
	a_sel_end: assert property (p_sel_end)
		else $error("strobe dropped early");
	property p_prot;
		awvalid && awready && !awprot[0] |->
			##[1:8] (bvalid && bresp == 2'h2);
	endproperty
	a_prot: assert property (p_prot)
		else $error("user write not refused");
	property p_width_hold;
		acc_busy && $past(acc_busy) |-> $stable(bus_8bit);
	endproperty
	a_width_hold: assert property (p_width_hold)
		else $error("width changed in access");
endmodule
bind chip_select_wait_control csw_asserts chk (
	.mclk                (mclk),
	.rst_b               (rst_b),
	.awvalid             (awvalid),
	.awready             (awready),
	.awprot              (awprot),
	.bvalid              (bvalid),
	.bresp               (bresp),
	.acc_start           (acc_start),
	.acc_addr            (acc_addr),
	.acc_busy            (acc_busy),
	.acc_done            (acc_done),
	.select_out_0        (select_out_0),
	.select_out_1        (select_out_1),
	.select_out_2        (select_out_2),
	.column_strobe_out_0 (column_strobe_out_0),
	.column_strobe_out_1 (column_strobe_out_1),
	.column_strobe_out_2 (column_strobe_out_2),
	.bus_8bit            (bus_8bit)
);

// >>> verif/ext_device.sv
// External device on the expansion bus, able to stretch accesses.
// Assumes the wait line has a pull-up, so released means high.
`timescale 1ns/1ps
module ext_device (
	// Clock
	input  wire       mclk,
	// Strobes from the controller
	input  wire       select_out_0,
	input  wire       select_out_1,
	input  wire       select_out_2,
	input  wire       column_strobe_out_0,
	input  wire       column_strobe_out_1,
	input  wire       column_strobe_out_2,
	// Cycles to hold wait, zero for a prompt device
	input  wire [3:0] stretch,
	// Active low wait request
	output wire       wait_pin_b
);
	wire        act;
	logic [3:0] cnt;
	assign act = select_out_0 | select_out_1 | select_out_2 |
		column_strobe_out_0 | column_strobe_out_1 | column_strobe_out_2;
	initial cnt = 4'h0;
	always @(posedge mclk)
		cnt <= act ? cnt + 4'h1 : 4'h0;
	assign wait_pin_b = !(act && cnt < stretch);
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the chip select and wait controller.
// Assumes csw_defs.vh on the include path; far side is ext_device.
`timescale 1ns/1ps
`include "csw_defs.vh"
module tb_top;
	logic        mclk, rst_b, awvalid, wvalid, bready, arvalid, rready;
	logic        acc_start, acc_system;
	logic [11:0] awaddr, araddr;
	logic [2:0]  awprot, arprot;
	logic [31:0] wdata, d;
	logic [3:0]  wstrb, stretch;
	logic [23:0] acc_addr;
	logic [1:0]  r;
	wire         awready, wready, bvalid, arready, rvalid;
	wire         acc_busy, acc_done, wait_pin_b, bus_8bit;
	wire         select_out_0, select_out_1, select_out_2;
	wire         column_strobe_out_0, column_strobe_out_1;
	wire         column_strobe_out_2;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	int          fails, total_checks, cyc, len;
	chip_select_wait_control dut (.*);
	ext_device far_end (.*);
	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end
	task test_done;
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails = fails + 1;
			test_done;
		end
	end
	task chk(input logic [33:0] got, input logic [33:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function logic [11:0] ad(input logic [7:0] b);
		return {2'h0, `IDX_BLOCK0 + b, 2'h0};
	endfunction
	task wr(input logic [11:0] a, input logic [7:0] v, input logic [2:0] p);
		@(posedge mclk);
		awaddr <= a;
		wdata <= {24'h00_0000, v};
		awprot <= p;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		r = bresp;
	endtask
	task rd(input logic [11:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
		d = rdata;
		r = rresp;
	endtask
	// Strobes seen in the first access cycle: {width, strobes, selects}
	task acc(input logic [23:0] a, input logic s, input logic [6:0] es,
		input int en);
		logic [6:0] seen;
		@(posedge mclk);
		acc_addr <= a;
		acc_system <= s;
		acc_start <= 1'h1;
		@(posedge mclk);
		acc_start <= 1'h0;
		len = 0;
		do begin
			@(posedge mclk);
			#1;
			len++;
			if (len == 1)
				seen = {bus_8bit, column_strobe_out_2, column_strobe_out_1,
					column_strobe_out_0, select_out_2, select_out_1,
					select_out_0};
		end while (!acc_done && len < 40);
		chk(seen, es);
		if (en > 0) chk(len, en);
	endtask
	task wa(input logic [7:0] b, v, input logic [23:0] a,
		input logic [6:0] es);
		wr(ad(b), v, 3'h1);
		acc(a, 1'h1, es, 4);
	endtask
	initial begin
		{rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{acc_start, acc_system, awaddr, araddr, awprot, arprot} = 32'h0000_0000;
		{wdata, acc_addr} = 56'h00_0000_0000_0000;
		wstrb = 4'hf;
		stretch = 4'h0;
		fails = 0;
		total_checks = 0;
		cyc = 0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'h1;
		acc(24'h80_0000, 1'h0, 7'h04, 4);
		acc(24'h00_7f00, 1'h1, 7'h00, 4);
		rd(ad(2));
		chk({r, d}, {`RESP_OKAY, 32'h0000_0000});
		rd(12'h000);
		chk(r, `RESP_SLVERR);
		wr(ad(0), 8'h80, 3'h0);
		chk(r, `RESP_SLVERR);
		acc(24'h00_7f00, 1'h1, 7'h00, 4);
		wr(12'h000, 8'h80, 3'h1);
		chk(r, `RESP_SLVERR);
		wa(0, 8'h80, 24'h00_7f80, 7'h01);
		acc(24'h00_7eff, 1'h1, 7'h00, 4);
		wa(0, 8'h81, 24'h40_0000, 7'h01);
		wa(0, 8'h82, 24'h80_0000, 7'h01);
		wa(0, 8'h83, 24'hc0_0000, 7'h01);
		wa(0, 8'h00, 24'h48_0000, 7'h00);
		wa(1, 8'h80, 24'h48_0000, 7'h02);
		acc(24'h47_ffff, 1'h1, 7'h00, 4);
		wa(1, 8'h81, 24'h40_0000, 7'h02);
		wa(1, 8'h00, 24'h40_0000, 7'h00);
		wa(2, 8'h81, 24'h40_0000, 7'h04);
		wa(2, 8'h83, 24'hc0_0000, 7'h04);
		wa(2, 8'hb0, 24'h80_0000, 7'h60);
		// Status keeps the width of the last access, all strobes idle
		rd(ad(3));
		chk({r, d}, {`RESP_OKAY, 32'h0000_0080});
		wr(ad(2), 8'hc0, 3'h1);
		acc(24'h80_0000, 1'h0, 7'h00, 4);
		acc(24'h80_0000, 1'h1, 7'h04, 4);
		for (int c = 0; c < 4; c++) begin
			wr(ad(2), {4'h8, c[1:0], 2'h0}, 3'h1);
			acc(24'h80_0000, 1'h1, 7'h04, c == 0 ? 4 : c == 3 ? 2 : 3);
		end
		stretch <= 4'h6;
		wr(ad(2), 8'h84, 3'h1);
		acc(24'h80_0000, 1'h1, 7'h04, 3);
		wr(ad(2), 8'h88, 3'h1);
		acc(24'h80_0000, 1'h1, 7'h04, 0);
		chk(len > 3, 1'h1);
		// Byte lane 0 off: write is answered but leaves block 2 alone
		wstrb <= 4'he;
		wr(ad(2), 8'h00, 3'h1);
		chk(r, `RESP_OKAY);
		wstrb <= 4'hf;
		acc(24'h80_0000, 1'h1, 7'h04, 0);
		test_done;
	end
endmodule
